//--- shared/fps_defines.vh
// Constants of the frame-rate prescaler and static-output block.
`ifndef FPS_DEFINES_VH
`define FPS_DEFINES_VH

// Command byte patterns and field positions.
`define FPS_CMD_LCD_PAT      3'h1
`define FPS_CMD_LCD_MSB      7
`define FPS_CMD_LCD_LSB      5
`define FPS_CMD_PWM_PAT      4'h4
`define FPS_CMD_PWM_MSB      7
`define FPS_CMD_PWM_LSB      4
`define FPS_CMD_STLO_PAT     5'h0c
`define FPS_CMD_STHI_PAT     5'h0d
`define FPS_CMD_ST_MSB       7
`define FPS_CMD_ST_LSB       3
`define FPS_LCD_FIELD_MSB    4
`define FPS_PWM_FIELD_MSB    3
`define FPS_ST_FIELD_MSB     2
`define FPS_LCD_CODE_MAX     5'h16

// Reset values.
`define FPS_LCD_SEL_RESET    5'h0e
`define FPS_PWM_SEL_RESET    4'h7
`define FPS_STATIC_RESET     3'h0

// Output mode that selects the static level.
`define FPS_MODE_STATIC      2'h2

// Frame divisors.
`define FPS_LCD_FRAME_DIV    8'h30
`define FPS_PWM_FRAME_DIV    8'h80

// Timing: reference clock and the 230 kHz internal oscillator it emulates.
`define FPS_REF_CLK_HZ       200000000
`define FPS_INT_OSC_HZ       230000
`define FPS_INT_OSC_CYCLES   (`FPS_REF_CLK_HZ / `FPS_INT_OSC_HZ)

`endif

//--- design/fps_sync3.v
// Three-stage synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/10ps
`default_nettype none
module fps_sync3 (
   // Clock and reset
   input  wire refClk,
   input  wire resetN,
   // Asynchronous input
   input  wire asyncIn,
   // Synchronised level and rising-edge pulse
   output reg  level_q,
   output reg  rise_q
);
   reg stage1_q;
   reg stage2_q;
   reg stage3_q;

   // The first stage is read only by the second to keep metastability contained.
   always @(posedge refClk or negedge resetN) begin
      if (!resetN) begin
         stage1_q <= 1'b0;
         stage2_q <= 1'b0;
         stage3_q <= 1'b0;
         level_q  <= 1'b0;
         rise_q   <= 1'b0;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         rise_q   <= 1'b0;
         if (stage2_q == stage3_q) begin
            level_q <= stage3_q;
            rise_q  <= stage3_q & ~level_q;
         end
      end
   end
endmodule // fps_sync3
`default_nettype wire

//--- design/fps_frame_div.v
// Tick-driven modulo counter that emits one pulse per full count.
`timescale 1ns/10ps
`default_nettype none
module fps_frame_div (
   // Clock and reset
   input  wire       refClk,
   input  wire       resetN,
   // Input tick and modulus
   input  wire       tickIn,
   input  wire [7:0] modulus,
   // Output pulse and running count
   output reg        pulse_q,
   output reg  [7:0] count_q
);
   // Wrapping on greater-or-equal keeps the counter sane when the modulus shrinks mid-count.
   always @(posedge refClk or negedge resetN) begin
      if (!resetN) begin
         count_q <= 8'h00;
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= 1'b0;
         if (tickIn) begin
            if (count_q >= modulus - 8'h01) begin
               count_q <= 8'h00;
               pulse_q <= 1'b1;
            end else begin
               count_q <= count_q + 8'h01;
            end
         end
      end
   end
endmodule // fps_frame_div
`default_nettype wire

//--- design/fps_prescaler_top.v
// Frame-rate prescalers for LCD and PWM plus the six static output levels.
//
// Contract
// - Byte with top bits 001 loads the five-bit LCD divider select; the code drops codes above 10110 and keeps the old select.
// - Slow 9.6 kHz clock: one LCD frame per 48 clock periods, select ignored.
// - 230 kHz clock: one LCD frame per 48 times q clock periods.
// - LCD select maps to q by the fixed table; reset code 01110.
// - Internal oscillator may drive system clock divided by q on the oscillator pin.
// - Byte with top bits 0100 loads the four-bit PWM divider select.
// - 230 kHz clock: one PWM frame per 128 times p clock periods.
// - PWM select maps to p by the fixed table; reset code 0111.
// - PWM frame timing always runs from a 230 kHz clock.
// - Static-mode outputs drive their stored static level constantly.
// - Byte with top bits 01100 loads static levels 2..0 from bits 2..0.
// - Byte with top bits 01101 loads static levels 5..3 from bits 2..0.
// - Static levels reset to 0 (low); writing 1 drives high.
// - Clock-rate select 0 means 9600 Hz, 1 means 230000 Hz.
// - Output uses its static level only when its mode field is 10.
// - PWM with slow external clock starts the internal oscillator for PWM timing.
`timescale 1ns/10ps
`default_nettype none
`include "fps_defines.vh"
module fps_prescaler_top (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        reset_n,
   // Command byte from the bus front end
   input  wire        cmdValid,
   input  wire [7:0]  cmdByte,
   // Clock configuration from the oscillator-control settings
   input  wire        externalClockSelect,
   input  wire        clockRateSelect,
   input  wire        clockOutEnable,
   input  wire        pwmEnable,
   // Output mode fields, two bits per output
   input  wire [11:0] outputModeField,
   // Oscillator pin
   input  wire        oscPinIn,
   output reg         oscPinOut_q,
   output reg         oscPinOe_q,
   // Frame timing
   output reg         lcdFrameTick_q,
   output reg         pwmFrameTick_q,
   output reg         oscillatorRunning_q,
   // Static outputs
   output reg  [5:0]  staticLevelOut_q,
   output reg  [5:0]  staticEnable_q,
   // Configuration state
   output reg  [4:0]  lcdFrameDividerSelect_q,
   output reg  [3:0]  pwmFrameDividerSelect_q
);
   reg  [2:0]  staticLevelLow_q;
   reg  [2:0]  staticLevelHigh_q;
   reg  [9:0]  oscCount_q;
   reg         intTick_q;
   reg         lcdClkTick_q;
   reg         pwmClkTick_q;
   reg  [7:0]  qFactor;
   reg  [7:0]  pFactor;
   wire        extLevel;
   wire        extRise;
   wire        qPulse;
   wire [7:0]  qCount;
   wire        lcdFramePulse;
   wire        pPulse;
   wire        pwmFramePulse;
   wire        slowMode;
   wire        oscRunning;
   wire        lcdBaseTick;
   wire [5:0]  staticLevelAll;
   wire [9:0]  oscLast;
   wire [31:0] oscLastWide;
   wire        lcdCmdHit;
   wire        lcdCodeValid;
   wire        pwmCmdHit;
   wire        staticLowCmdHit;
   wire        staticHighCmdHit;
   wire        pwmFromPin;
   wire        lcdTickSrc;
   wire        pwmTickSrc;
   wire        pinDriveOn;
   wire        pinHalfHigh;
   wire [5:0]  staticModeHit;

   // The divide yields a 32-bit integer; only the low ten bits hold the period.
   assign oscLastWide    = `FPS_INT_OSC_CYCLES - 1;
   assign oscLast        = oscLastWide[9:0];
   assign staticLevelAll = {staticLevelHigh_q, staticLevelLow_q};

   // Slow mode only exists with an external clock; select 0 means 9600 Hz.
   assign slowMode   = externalClockSelect & ~clockRateSelect;
   // The internal oscillator also runs when PWM needs 230 kHz but the pin gives 9.6 kHz.
   assign oscRunning = ~externalClockSelect | (pwmEnable & slowMode);

   // Pattern matches are kept apart so each command visibly touches only its own field.
   assign lcdCmdHit        = (cmdByte[`FPS_CMD_LCD_MSB:`FPS_CMD_LCD_LSB] == `FPS_CMD_LCD_PAT);
   assign lcdCodeValid     = (cmdByte[`FPS_LCD_FIELD_MSB:0] <= `FPS_LCD_CODE_MAX);
   assign pwmCmdHit        = (cmdByte[`FPS_CMD_PWM_MSB:`FPS_CMD_PWM_LSB] == `FPS_CMD_PWM_PAT);
   assign staticLowCmdHit  = (cmdByte[`FPS_CMD_ST_MSB:`FPS_CMD_ST_LSB] == `FPS_CMD_STLO_PAT);
   assign staticHighCmdHit = (cmdByte[`FPS_CMD_ST_MSB:`FPS_CMD_ST_LSB] == `FPS_CMD_STHI_PAT);

   // Command decode: each pattern touches only its own field.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lcdFrameDividerSelect_q <= `FPS_LCD_SEL_RESET;
         pwmFrameDividerSelect_q <= `FPS_PWM_SEL_RESET;
         staticLevelLow_q        <= `FPS_STATIC_RESET;
         staticLevelHigh_q       <= `FPS_STATIC_RESET;
      end else if (cmdValid) begin
         // Codes past the last table entry have no divide factor and are dropped.
         if (lcdCmdHit && lcdCodeValid) begin
            lcdFrameDividerSelect_q <= cmdByte[`FPS_LCD_FIELD_MSB:0];
         end
         if (pwmCmdHit) begin
            pwmFrameDividerSelect_q <= cmdByte[`FPS_PWM_FIELD_MSB:0];
         end
         if (staticLowCmdHit) begin
            staticLevelLow_q <= cmdByte[`FPS_ST_FIELD_MSB:0];
         end
         if (staticHighCmdHit) begin
            staticLevelHigh_q <= cmdByte[`FPS_ST_FIELD_MSB:0];
         end
      end
   end

   // Divide factor q for the LCD prescaler.
   always @* begin
      case (lcdFrameDividerSelect_q)
         5'h00:   qFactor = 8'h50;
         5'h01:   qFactor = 8'h44;
         5'h02:   qFactor = 8'h3c;
         5'h03:   qFactor = 8'h35;
         5'h04:   qFactor = 8'h30;
         5'h05:   qFactor = 8'h2c;
         5'h06:   qFactor = 8'h28;
         5'h07:   qFactor = 8'h25;
         5'h08:   qFactor = 8'h22;
         5'h09:   qFactor = 8'h20;
         5'h0a:   qFactor = 8'h1e;
         5'h0b:   qFactor = 8'h1c;
         5'h0c:   qFactor = 8'h1b;
         5'h0d:   qFactor = 8'h19;
         5'h0e:   qFactor = 8'h18;
         5'h0f:   qFactor = 8'h17;
         5'h10:   qFactor = 8'h16;
         5'h11:   qFactor = 8'h15;
         5'h12:   qFactor = 8'h14;
         5'h13:   qFactor = 8'h13;
         5'h14:   qFactor = 8'h12;
         5'h15:   qFactor = 8'h11;
         5'h16:   qFactor = 8'h10;
         default: qFactor = 8'h18;
      endcase
   end

   // Divide factor p for the PWM prescaler.
   always @* begin
      case (pwmFrameDividerSelect_q)
         4'h0:    pFactor = 8'h1e;
         4'h1:    pFactor = 8'h1a;
         4'h2:    pFactor = 8'h16;
         4'h3:    pFactor = 8'h14;
         4'h4:    pFactor = 8'h12;
         4'h5:    pFactor = 8'h10;
         4'h6:    pFactor = 8'h0f;
         4'h7:    pFactor = 8'h0e;
         4'h8:    pFactor = 8'h0d;
         4'h9:    pFactor = 8'h0c;
         4'ha:    pFactor = 8'h0b;
         4'hb:    pFactor = 8'h0a;
         4'hc:    pFactor = 8'h09;
         4'hd:    pFactor = 8'h08;
         4'he:    pFactor = 8'h07;
         default: pFactor = 8'h06;
      endcase
   end

   // The oscillator pin comes from another clock domain.
   fps_sync3 u_pinSync (
      .refClk  (ref_clk),
      .resetN  (reset_n),
      .asyncIn (oscPinIn),
      .level_q (extLevel),
      .rise_q  (extRise)
   );

   // Internal 230 kHz oscillator emulated as an enable pulse from the reference clock.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         oscCount_q <= 10'h000;
         intTick_q  <= 1'b0;
      end else begin
         intTick_q <= 1'b0;
         if (!oscRunning) begin
            oscCount_q <= 10'h000;
         end else if (oscCount_q == oscLast) begin
            oscCount_q <= 10'h000;
            intTick_q  <= 1'b1;
         end else begin
            oscCount_q <= oscCount_q + 10'h001;
         end
      end
   end

   // The PWM clock is taken from the pin only when the pin carries the full 230 kHz.
   assign pwmFromPin = externalClockSelect & clockRateSelect;
   assign lcdTickSrc = externalClockSelect ? extRise : intTick_q;
   assign pwmTickSrc = pwmFromPin ? extRise : intTick_q;

   // Clock ticks feeding the LCD and PWM timing.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lcdClkTick_q <= 1'b0;
         pwmClkTick_q <= 1'b0;
      end else begin
         lcdClkTick_q <= lcdTickSrc;
         // A 9.6 kHz pin clock would make the LEDs flicker, so PWM falls back to the oscillator.
         pwmClkTick_q <= pwmTickSrc;
      end
   end

   // LCD prescaler by q; its count also shapes the intermediate clock on the pin.
   fps_frame_div u_lcdPrescale (
      .refClk  (ref_clk),
      .resetN  (reset_n),
      .tickIn  (lcdClkTick_q),
      .modulus (qFactor),
      .pulse_q (qPulse),
      .count_q (qCount)
   );

   // In slow mode the prescaler is bypassed and the frame divider sees every clock.
   assign lcdBaseTick = slowMode ? lcdClkTick_q : qPulse;

   fps_frame_div u_lcdFrame (
      .refClk  (ref_clk),
      .resetN  (reset_n),
      .tickIn  (lcdBaseTick),
      .modulus (`FPS_LCD_FRAME_DIV),
      .pulse_q (lcdFramePulse),
      .count_q ()
   );

   // PWM prescaler by p; the frame divider behind it then counts the 128 PWM steps.
   fps_frame_div u_pwmPrescale (
      .refClk  (ref_clk),
      .resetN  (reset_n),
      .tickIn  (pwmClkTick_q),
      .modulus (pFactor),
      .pulse_q (pPulse),
      .count_q ()
   );

   fps_frame_div u_pwmFrame (
      .refClk  (ref_clk),
      .resetN  (reset_n),
      .tickIn  (pPulse),
      .modulus (`FPS_PWM_FRAME_DIV),
      .pulse_q (pwmFramePulse),
      .count_q ()
   );

   // Pin is high for the first q/2 counts of each q, about half duty; the pin is only driven off the internal oscillator.
   assign pinDriveOn  = ~externalClockSelect & clockOutEnable;
   assign pinHalfHigh = (qCount < {1'b0, qFactor[7:1]});

   // Registered outputs.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lcdFrameTick_q      <= 1'b0;
         pwmFrameTick_q      <= 1'b0;
         oscillatorRunning_q <= 1'b0;
         oscPinOut_q         <= 1'b0;
         oscPinOe_q          <= 1'b0;
      end else begin
         lcdFrameTick_q      <= lcdFramePulse;
         pwmFrameTick_q      <= pwmFramePulse;
         oscillatorRunning_q <= oscRunning;
         oscPinOe_q          <= pinDriveOn;
         oscPinOut_q         <= pinDriveOn & pinHalfHigh;
      end
   end

   // Static outputs, one per channel.
   genvar ch;
   generate
      for (ch = 0; ch < 6; ch = ch + 1) begin : g_static
         assign staticModeHit[ch] = (outputModeField[2*ch+1:2*ch] == `FPS_MODE_STATIC);
         always @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               staticEnable_q[ch]   <= 1'b0;
               staticLevelOut_q[ch] <= 1'b0;
            end else begin
               staticEnable_q[ch]   <= staticModeHit[ch];
               staticLevelOut_q[ch] <= staticLevelAll[ch];
            end
         end
      end
   endgenerate
endmodule // fps_prescaler_top
`default_nettype wire

//--- dv/fps_host_model.sv
// Host model that sends command bytes and supplies the external clock.
`timescale 1ns/10ps
`default_nettype none
module fps_host_model (
   // Clock and control
   input  wire logic       ref_clk,
   input  wire logic       runClk,
   // Command port
   output var  logic       cmdValid,
   output var  logic [7:0] cmdByte,
   // External clock
   output var  logic       extClk
);
   logic [1:0] phase;
   int         edges;
   initial begin
      cmdValid = 1'b0;
      cmdByte  = 8'h00;
      extClk   = 1'b0;
      phase    = 2'h0;
      edges    = 0;
   end
   // One whole byte per strobe; call at a falling edge, back to back allowed.
   task automatic send(input logic [7:0] b);
      cmdValid = 1'b1;
      cmdByte  = b;
      @(negedge ref_clk);
   endtask
   // A released byte shows its inverse so a stale value cannot pass for a real one.
   task automatic idle();
      cmdValid = 1'b0;
      cmdByte  = ~cmdByte;
      @(negedge ref_clk);
   endtask
   always @(negedge ref_clk) begin
      if (runClk) begin
         phase <= phase + 2'h1;
         if (phase == 2'h3) begin
            extClk <= ~extClk;
            edges  <= edges + (extClk ? 0 : 1);
         end
      end
   end
endmodule // fps_host_model
`default_nettype wire

//--- dv/fps_prescaler_top_asserts.sv
// Checker for the prescaler block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module fps_prescaler_top_asserts (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        reset_n,
   // Command and configuration inputs
   input wire logic        cmdValid,
   input wire logic [7:0]  cmdByte,
   input wire logic        externalClockSelect,
   input wire logic        clockRateSelect,
   input wire logic        clockOutEnable,
   input wire logic        pwmEnable,
   input wire logic [11:0] outputModeField,
   // Design outputs
   input wire logic        oscPinOe_q,
   input wire logic        lcdFrameTick_q,
   input wire logic        oscillatorRunning_q,
   input wire logic [5:0]  staticLevelOut_q,
   input wire logic [5:0]  staticEnable_q,
   input wire logic [4:0]  lcdFrameDividerSelect_q,
   input wire logic [3:0]  pwmFrameDividerSelect_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic       lcdOk;
   logic       pwmCmd;
   logic [5:0] modeStatic;
   assign lcdOk  = cmdValid && cmdByte[7:5] == 3'h1 && cmdByte[4:0] <= 5'h16;
   assign pwmCmd = cmdValid && cmdByte[7:4] == 4'h4;
   always_comb
      for (int i = 0; i < 6; i++) modeStatic[i] = outputModeField[2*i+:2] == 2'h2;
   sequence s_low_cmd;
      cmdValid && cmdByte[7:3] == 5'h0c;
   endsequence
   sequence s_high_cmd;
      cmdValid && cmdByte[7:3] == 5'h0d;
   endsequence
   a_lcd_sel_load: assert property (lcdOk |=> lcdFrameDividerSelect_q == $past(cmdByte[4:0]))
      else $error("lcd select not loaded");
   a_lcd_sel_hold: assert property (!lcdOk |=> $stable(lcdFrameDividerSelect_q))
      else $error("lcd select changed");
   a_pwm_sel_load: assert property (pwmCmd |=> pwmFrameDividerSelect_q == $past(cmdByte[3:0]))
      else $error("pwm select not loaded");
   a_pwm_sel_hold: assert property (!pwmCmd |=> $stable(pwmFrameDividerSelect_q))
      else $error("pwm select changed");
   a_static_low_load: assert property (s_low_cmd |-> ##2 staticLevelOut_q[2:0] == $past(cmdByte[2:0], 2))
      else $error("low static levels wrong");
   a_static_high_load: assert property (s_high_cmd |-> ##2 staticLevelOut_q[5:3] == $past(cmdByte[2:0], 2))
      else $error("high static levels wrong");
   a_pin_drive_enable: assert property ($past(reset_n) |-> oscPinOe_q == $past(!externalClockSelect && clockOutEnable))
      else $error("pin enable wrong");
   a_static_mode_enable: assert property ($past(reset_n) |-> staticEnable_q == $past(modeStatic))
      else $error("static enable wrong");
   a_osc_auto_start: assert property ($past(reset_n) |-> oscillatorRunning_q ==
      $past(!externalClockSelect || (pwmEnable && !clockRateSelect))) else $error("oscillator state wrong");
   a_lcd_tick_pulse: assert property (lcdFrameTick_q |=> !lcdFrameTick_q)
      else $error("lcd tick too long");
endmodule // fps_prescaler_top_asserts
bind fps_prescaler_top fps_prescaler_top_asserts u_asserts (.*);
`default_nettype wire

//--- dv/tb.sv
// Self-checking testbench for the prescaler block.
`timescale 1ns/10ps
`default_nettype none
`include "fps_defines.vh"
module tb;
   typedef struct packed {logic [7:0] cmd; logic [4:0] lcd; logic [3:0] pwm; logic [5:0] st;} fps_row_t;
   logic        ref_clk, reset_n, externalClockSelect, clockRateSelect, clockOutEnable, pwmEnable, runClk;
   logic        cmdValid, extClk, pin, oscPinOut_q, oscPinOe_q, lcdFrameTick_q, pwmFrameTick_q, oscillatorRunning_q;
   logic [7:0]  cmdByte;
   logic [11:0] outputModeField;
   logic [5:0]  staticLevelOut_q, staticEnable_q;
   logic [4:0]  lcdFrameDividerSelect_q;
   logic [3:0]  pwmFrameDividerSelect_q;
   int          n_mismatch, checks, cyc, e0, k;
   fps_row_t    rows [11] = '{'{8'h00, 5'h0e, 4'h7, 6'h00}, '{8'h36, 5'h16, 4'h7, 6'h00}, '{8'h37, 5'h16, 4'h7, 6'h00},
      '{8'h20, 5'h00, 4'h7, 6'h00}, '{8'h4f, 5'h00, 4'hf, 6'h00}, '{8'h40, 5'h00, 4'h0, 6'h00},
      '{8'h65, 5'h00, 4'h0, 6'h05}, '{8'h62, 5'h00, 4'h0, 6'h02}, '{8'h6a, 5'h00, 4'h0, 6'h12},
      '{8'h70, 5'h00, 4'h0, 6'h12}, '{8'h9f, 5'h00, 4'h0, 6'h12}};
   fps_prescaler_top dut (.*, .oscPinIn(pin));
   fps_host_model host (.*);
   assign pin = oscPinOe_q ? oscPinOut_q : extClk;
   initial ref_clk = 1'b0;
   always #2.5 ref_clk = ~ref_clk;
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Counts external clock edges between two frame ticks; the pulse latency cancels out.
   task automatic frame(input logic pwm, input int exp);
      for (int j = 0; j < 2; j++) begin
         k = 0;
         do begin
            @(posedge ref_clk);
            #1 k++;
         end while (!(pwm ? pwmFrameTick_q : lcdFrameTick_q) && k < 20000);
         check("frameWait", k < 20000, 1'b1);
         if (j == 0) e0 = host.edges;
      end
      check("frameEdges", host.edges - e0, exp);
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 100000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      {reset_n, externalClockSelect, pwmEnable, runClk, outputModeField} = '0;
      {clockRateSelect, clockOutEnable} = 2'b11;
      repeat (2) @(negedge ref_clk);
      reset_n = 1'b1;
      foreach (rows[i]) begin
         host.send(rows[i].cmd);
         host.idle();
         @(negedge ref_clk);
         check("lcdSel", lcdFrameDividerSelect_q, rows[i].lcd);
         check("pwmSel", pwmFrameDividerSelect_q, rows[i].pwm);
         check("static", staticLevelOut_q, rows[i].st);
      end
      for (int i = 0; i < 23; i++) host.send({3'h1, 5'(i)});
      for (int i = 0; i < 16; i++) host.send({4'h4, 4'(i)});
      host.send(8'h67);
      host.send(8'h6d);
      host.idle();
      @(negedge ref_clk);
      check("lcdLast", lcdFrameDividerSelect_q, 5'h16);
      check("pwmLast", pwmFrameDividerSelect_q, 4'hf);
      check("staticPair", staticLevelOut_q, 6'h2f);
      outputModeField = 12'b10_11_01_00_10_10;
      check("pinEnable", oscPinOe_q, 1'b1);
      check("oscRun", oscillatorRunning_q, 1'b1);
      repeat (2) @(negedge ref_clk);
      check("staticEn", staticEnable_q, 6'b100011);
      k = 0;
      for (int j = 0; j < 4; j++) begin
         if (j == 2) k = 0;
         while (oscPinOut_q === (j % 2 == 0) && k < 40000) begin
            @(posedge ref_clk);
            #1 k++;
         end
      end
      @(negedge ref_clk);
      check("midClock", k, 16 * `FPS_INT_OSC_CYCLES);
      {externalClockSelect, clockRateSelect, pwmEnable, runClk} = 4'b1011;
      repeat (2) @(negedge ref_clk);
      check("pinEnable", oscPinOe_q, 1'b0);
      check("oscRun", oscillatorRunning_q, 1'b1);
      frame(1'b0, 48);
      @(negedge ref_clk);
      {clockRateSelect, pwmEnable} = 2'b10;
      repeat (2) @(negedge ref_clk);
      check("oscRun", oscillatorRunning_q, 1'b0);
      frame(1'b0, 48 * 16);
      @(negedge ref_clk);
      host.send(8'h4d);
      host.idle();
      check("pwmSel", pwmFrameDividerSelect_q, 4'hd);
      frame(1'b1, 128 * 8);
      @(negedge ref_clk);
      {externalClockSelect, clockOutEnable} = 2'b00;
      repeat (2) @(negedge ref_clk);
      check("pinOff", {oscPinOe_q, oscPinOut_q}, 2'b00);
      reset_n = 1'b0;
      #1;
      check("rstLcd", lcdFrameDividerSelect_q, 5'h0e);
      check("rstPwm", pwmFrameDividerSelect_q, 4'h7);
      check("rstStatic", staticLevelOut_q, 6'h00);
      stop_test();
   end
endmodule // tb
`default_nettype wire
